//--- esq_pkg.sv
// constants, types and helpers shared by the serial memory command sequencer
// assumes a 10 MHz system clock and a serial clock that only runs inside frames
package esq_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

  // memory geometry
  localparam int unsigned MEM_WORDS = 256;
  localparam int unsigned PAGE_BYTES = 4;

  // opcodes, msb first on the serial input
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  // status byte layout
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_PROT_LO_BIT = 2;
  localparam int unsigned ST_PROT_HI_BIT = 3;
  localparam logic [7:0] ST_BUSY_VIEW = 8'hff;

  // protect level decode: lowest protected address per level
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF = 2'h2;
  localparam logic [7:0] PROT_QUARTER_BASE = 8'hc0;
  localparam logic [7:0] PROT_HALF_BASE = 8'h80;

  // values after reset
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic LATCH_RESET = 1'b0;
  localparam logic [7:0] SO_RESET = 8'h00;

  // times as printed, and the cycle counts derived from them
  localparam int unsigned T_PU_READ_MS = 1;
  localparam int unsigned T_PU_WRITE_MS = 5;
  localparam int unsigned T_WRITE_CYCLE_MS = 10;
  localparam int unsigned PU_READ_CYCLES = T_PU_READ_MS * (CLK_HZ / 1000);
  localparam int unsigned PU_WRITE_CYCLES = T_PU_WRITE_MS * (CLK_HZ / 1000);
  localparam int unsigned WRITE_CYCLES = T_WRITE_CYCLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;

  // link sequencer states, gray along opcode -> address -> read data
  typedef enum logic [2:0] {
    ESQ_OPCODE = 3'h0,
    ESQ_ADDR = 3'h1,
    ESQ_RD_DATA = 3'h3,
    ESQ_WR_DATA = 3'h2,
    ESQ_ST_READ = 3'h6,
    ESQ_ST_WDATA = 3'h7,
    ESQ_LATCH_CMD = 3'h5,
    ESQ_IGNORE = 3'h4
  } esq_state_t;

  // everything one frame has gathered, held after chip select rises
  typedef struct packed {
    esq_state_t state;
    logic [2:0] bitc;
    logic [7:0] shift;
    logic [7:0] op;
    logic [7:0] addr;
    logic [3:0][7:0] data;
    logic [3:0] mask;
    logic [7:0] sdata;
    logic have;
  } esq_frame_t;

  localparam esq_frame_t FRAME_INIT = '{
    state: ESQ_OPCODE, bitc: 3'h0, shift: 8'h00, op: 8'h00, addr: 8'h00,
    data: 32'h0000_0000, mask: 4'h0, sdata: 8'h00, have: 1'b0};

  // status byte as seen by a reader; all ones while a write runs
  function automatic logic [7:0] status_byte(input logic busy, input logic latch, input logic [1:0] prot);
    logic [7:0] s;
    s = 8'h00;
    s[ST_LATCH_BIT] = latch;
    s[ST_PROT_LO_BIT] = prot[0];
    s[ST_PROT_HI_BIT] = prot[1];
    status_byte = busy ? ST_BUSY_VIEW : s;
  endfunction

  // true when the protect level covers this array address
  function automatic logic is_protected(input logic [1:0] prot, input logic [7:0] a);
    unique case (prot)
      PROT_NONE: is_protected = 1'b0;
      PROT_QUARTER: is_protected = (a >= PROT_QUARTER_BASE);
      PROT_HALF: is_protected = (a >= PROT_HALF_BASE);
      default: is_protected = 1'b1;
    endcase
  endfunction

endpackage

//--- esq_sync.sv
// two-stage level synchroniser, one bit per lane
// assumes each lane is a slowly changing level from another domain
`timescale 1ns/1ps
module esq_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic nrst,
  // foreign levels in, settled levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

//--- esq_top.sv
// serial nonvolatile memory command sequencer, device side
// assumes the host drives sck, cs_n, si and hold_n; sck idles outside frames
//
// What this block does
// - after opcode and address, the addressed byte shifts out on so
// - continued clocks advance the read address after each byte
// - read address wraps from top back to zero
// - cs_n high ends the read and releases so
// - status-read opcode streams the status byte out on so
// - latch commands count only if cs_n rises right after eight bits
// - at most four data bytes per write, all in one page
// - write data wraps within the page, later bytes replace earlier ones
// - write starts only if cs_n rises just after a complete data byte
// - status reads work during a write and show the busy flag set
// - hold_n low pauses the transfer, high resumes where it stopped
// - after power-up, instructions need a cs_n falling edge first
// - so is released at power-up
// - write latch is clear at power-up
// - opcode decode for latch set, latch clear, status read and the rest
// - status holds busy, latch and two protect bits; only protect is writable
// - protect level guards none, upper quarter, upper half or whole array
// - write latch clears when any write cycle completes
`timescale 1ns/1ps
module esq_top
  import esq_pkg::*;
#(
  parameter int unsigned PU_READ_CNT = PU_READ_CYCLES,
  parameter int unsigned PU_WRITE_CNT = PU_WRITE_CYCLES,
  parameter int unsigned WRITE_CNT = WRITE_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  output logic so,
  output logic so_oe,
  // write protect pin
  input wire logic wp_n,
  // status and readiness
  output logic [7:0] status_o,
  output logic read_ready,
  output logic write_ready
);

  // link domain state
  esq_frame_t frame_r;
  esq_frame_t frame_nxt;
  logic fresh_r;
  logic link_rst_n;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] tx_byte;
  logic [7:0] rd_word;

  // levels from the system domain, settled on sck
  logic [4:0] sys_lvl;
  logic [4:0] sys_lvl_s;
  logic busy_s;
  logic latch_s;
  logic armed_s;
  logic [1:0] prot_s;

  // system domain state
  logic [1:0] pin_s;
  logic cs_s;
  logic wp_s;
  logic cs_d_r;
  logic cs_rise;
  logic armed_r;
  logic latch_r;
  logic busy_r;
  logic [1:0] prot_r;
  logic [CNT_W-1:0] wr_cnt_r;
  logic [CNT_W-1:0] pu_cnt_r;
  esq_frame_t pend_r;
  logic wr_go;
  logic wr_done;
  logic latch_cmd;
  logic [7:0] mem [MEM_WORDS];

  // chip select high clears the frame-scoped flops and the output drive
  assign link_rst_n = nrst & ~cs_n;

  // fresh_r low marks the first sck fall of a new frame
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fresh_r <= 1'b0;
    end else if (hold_n) begin
      fresh_r <= 1'b1;
    end
  end

  // receive side: input sampled on the falling sck edge
  always_comb begin
    esq_frame_t cur;
    cur = fresh_r ? frame_r : FRAME_INIT;
    frame_nxt = cur;
    rx_byte = {cur.shift[6:0], si};
    byte_done = (cur.bitc == 3'h7);
    frame_nxt.shift = rx_byte;
    frame_nxt.bitc = cur.bitc + 3'h1;
    unique case (cur.state)
      ESQ_OPCODE: begin
        if (byte_done) begin
          frame_nxt.op = rx_byte;
          if (!armed_s) begin
            frame_nxt.state = ESQ_IGNORE;
          end else if (busy_s && (rx_byte != OP_STATUS_READ)) begin
            frame_nxt.state = ESQ_IGNORE;
          end else begin
            unique case (rx_byte)
              OP_WRITE_LATCH_SET: frame_nxt.state = ESQ_LATCH_CMD;
              OP_WRITE_LATCH_CLEAR: frame_nxt.state = ESQ_LATCH_CMD;
              OP_STATUS_READ: frame_nxt.state = ESQ_ST_READ;
              OP_STATUS_WRITE: frame_nxt.state = ESQ_ST_WDATA;
              OP_ARRAY_READ: frame_nxt.state = ESQ_ADDR;
              OP_ARRAY_WRITE: frame_nxt.state = ESQ_ADDR;
              default: frame_nxt.state = ESQ_IGNORE;
            endcase
          end
        end
      end
      ESQ_ADDR: begin
        if (byte_done) begin
          frame_nxt.addr = rx_byte;
          frame_nxt.state = (cur.op == OP_ARRAY_READ) ? ESQ_RD_DATA : ESQ_WR_DATA;
        end
      end
      ESQ_RD_DATA: begin
        // 8-bit add wraps 0xff to 0x00 by itself
        if (byte_done) begin
          frame_nxt.addr = cur.addr + 8'h01;
        end
      end
      ESQ_WR_DATA: begin
        if (byte_done) begin
          frame_nxt.data[cur.addr[1:0]] = rx_byte;
          frame_nxt.mask[cur.addr[1:0]] = 1'b1;
          frame_nxt.addr = {cur.addr[7:2], cur.addr[1:0] + 2'h1};
          frame_nxt.have = 1'b1;
        end
      end
      ESQ_ST_WDATA: begin
        // extra bytes are taken too; the last whole one wins
        if (byte_done) begin
          frame_nxt.sdata = rx_byte;
          frame_nxt.have = 1'b1;
        end
      end
      ESQ_LATCH_CMD: begin
        // a ninth bit spoils the latch command
        frame_nxt.state = ESQ_IGNORE;
      end
      ESQ_ST_READ: begin
        frame_nxt.state = ESQ_ST_READ;
      end
      ESQ_IGNORE: begin
        frame_nxt.state = ESQ_IGNORE;
      end
    endcase
  end

  // frame survives cs_n rising so the system side can judge it
  // clk reads it as quasi-static, which holds only while sck idles with cs_n high
  always_ff @(negedge sck or negedge nrst) begin
    if (!nrst) begin
      frame_r <= FRAME_INIT;
    end else if (!cs_n && hold_n) begin
      frame_r <= frame_nxt;
    end
  end

  // array word is quasi-static: writes only land while reads are refused
  assign rd_word = mem[frame_r.addr];
  assign tx_byte = (frame_r.state == ESQ_ST_READ) ? status_byte(busy_s, latch_s, prot_s) : rd_word;

  // transmit side: so changes on the rising sck edge
  // paused rises leave so and so_oe alone: no rise comes after the resume to restore the drive
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so <= SO_RESET[0];
      so_oe <= 1'b0;
    end else if (hold_n) begin
      so_oe <= fresh_r && ((frame_r.state == ESQ_RD_DATA) || (frame_r.state == ESQ_ST_READ));
      so <= tx_byte[~frame_r.bitc];
    end
  end

  // system levels carried into the sck domain
  // lanes may settle one sck apart; only a status read in flight can see that
  assign sys_lvl = {prot_r, armed_r, latch_r, busy_r};
  assign busy_s = sys_lvl_s[0];
  assign latch_s = sys_lvl_s[1];
  assign armed_s = sys_lvl_s[2];
  assign prot_s = sys_lvl_s[4:3];

  esq_sync #(
    .W(5),
    .RST(5'h00)
  ) u_to_link (
    .clk(sck),
    .nrst(nrst),
    .d(sys_lvl),
    .q(sys_lvl_s)
  );

  // cs_n and wp_n settled on the system clock
  // reset low, so a select held low since power-up never counts as seen high
  esq_sync #(
    .W(2),
    .RST(2'h0)
  ) u_to_sys (
    .clk(clk),
    .nrst(nrst),
    .d({wp_n, cs_n}),
    .q(pin_s)
  );

  assign cs_s = pin_s[0];
  assign wp_s = pin_s[1];
  assign cs_rise = cs_s & ~cs_d_r;

  // end-of-frame edge; frame_r is still while cs_n stays high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_d_r <= 1'b1;
    end else begin
      cs_d_r <= cs_s;
    end
  end

  // armed once cs_n has been seen high after reset
  // the falling edge that opens the first frame can only follow this
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else if (cs_s) begin
      armed_r <= 1'b1;
    end
  end

  // frame verdicts at the rising chip select
  // armed_r also masks the one harmless rise that the low sync reset gives
  assign latch_cmd = cs_rise && armed_r && !busy_r && (frame_r.state == ESQ_LATCH_CMD) && (frame_r.bitc == 3'h0);
  assign wr_go = cs_rise && armed_r && !busy_r && latch_r && wp_s && frame_r.have && (frame_r.bitc == 3'h0)
    && ((frame_r.state == ESQ_WR_DATA) || (frame_r.state == ESQ_ST_WDATA));
  assign wr_done = busy_r && (wr_cnt_r == CNT_W'(WRITE_CNT - 1));

  // write enable latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= LATCH_RESET;
    end else if (wr_done) begin
      latch_r <= 1'b0;
    end else if (latch_cmd) begin
      latch_r <= (frame_r.op == OP_WRITE_LATCH_SET);
    end
  end

  // self-timed write cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      wr_cnt_r <= '0;
      pend_r <= FRAME_INIT;
    end else if (wr_go) begin
      busy_r <= 1'b1;
      wr_cnt_r <= '0;
      pend_r <= frame_r;
    end else if (wr_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      wr_cnt_r <= wr_cnt_r + CNT_W'(1);
    end
  end

  // protect bits: the only writable status field
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prot_r <= PROT_RESET;
    end else if (wr_done && (pend_r.state == ESQ_ST_WDATA)) begin
      prot_r <= {pend_r.sdata[ST_PROT_HI_BIT], pend_r.sdata[ST_PROT_LO_BIT]};
    end
  end

  // address of slot i inside the page that holds a
  function automatic logic [7:0] page_slot(input logic [7:0] a, input int unsigned i);
    page_slot = {a[7:2], 2'(i)};
  endfunction

  // array cells have no reset, like the nonvolatile cells they stand for
  always_ff @(posedge clk) begin
    if (wr_done && (pend_r.state == ESQ_WR_DATA)) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pend_r.mask[i] && !is_protected(prot_r, page_slot(pend_r.addr, i))) begin
          mem[page_slot(pend_r.addr, i)] <= pend_r.data[i];
        end
      end
    end
  end

  // power-up readiness counter saturates at the write delay
  // advisory only: frames are never refused on readiness
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pu_cnt_r <= '0;
      read_ready <= 1'b0;
      write_ready <= 1'b0;
    end else begin
      if (pu_cnt_r != CNT_W'(PU_WRITE_CNT)) begin
        pu_cnt_r <= pu_cnt_r + CNT_W'(1);
      end
      read_ready <= (pu_cnt_r >= CNT_W'(PU_READ_CNT));
      write_ready <= (pu_cnt_r >= CNT_W'(PU_WRITE_CNT));
    end
  end

  // status byte for the system side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_o <= 8'h00;
    end else begin
      status_o <= status_byte(busy_r, latch_r, prot_r);
    end
  end

endmodule

//--- esq_props.sv
// port-level timing checks for esq_top, attached by the bind at the foot
// assumes sck only toggles inside frames and cs_n changes while sck is low
`timescale 1ns/1ps
module esq_props #(
  parameter int unsigned PU_READ_CNT = 10,
  parameter int unsigned PU_WRITE_CNT = 20,
  parameter int unsigned WRITE_CNT = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe,
  // pins and status
  input wire logic wp_n,
  input wire logic [7:0] status_o,
  input wire logic read_ready,
  input wire logic write_ready
);
  logic [19:0] up_r;
  logic [7:0] desel_r;
  logic [19:0] busy_r;
  logic [5:0] rise_r;

  // clk cycles since reset, saturating so it never wraps back into the early window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_r <= 20'h00000;
    else if (up_r != 20'hfffff) up_r <= up_r + 20'h00001;
  end

  // cycles with cs_n high and cycles with busy set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      desel_r <= 8'h00;
      busy_r <= 20'h00000;
    end else begin
      desel_r <= !cs_n ? 8'h00 : (desel_r == 8'hff ? desel_r : desel_r + 8'h01);
      busy_r <= status_o[0] ? busy_r + 20'h00001 : 20'h00000;
    end
  end

  // sck rises counted in a frame; paused rises do not count
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) rise_r <= 6'h00;
    else if (cs_n) rise_r <= 6'h00;
    else if (hold_n && rise_r != 6'h3f) rise_r <= rise_r + 6'h01;
  end

  sequence s_busy_start;
    $rose(status_o[0]);
  endsequence

  sequence s_busy_end;
    $fell(status_o[0]);
  endsequence

  so_release_a: assert property (@(posedge clk) disable iff (!nrst) cs_n |-> !so_oe)
    else $error("so driven while deselected");
  reset_state_a: assert property (@(posedge clk) !nrst |-> status_o == 8'h00 && !so_oe && !read_ready)
    else $error("outputs not quiet in reset");
  busy_view_a: assert property (@(posedge clk) disable iff (!nrst) status_o[0] |-> status_o == 8'hff)
    else $error("busy status byte not all ones");
  read_early_a: assert property (@(posedge clk) disable iff (!nrst)
    int'(up_r) + 1 < int'(PU_READ_CNT) |-> !read_ready && !write_ready) else $error("read ready too early");
  write_early_a: assert property (@(posedge clk) disable iff (!nrst)
    int'(up_r) + 1 < int'(PU_WRITE_CNT) |-> !write_ready) else $error("write ready too early");
  ready_late_a: assert property (@(posedge clk) disable iff (!nrst)
    int'(up_r) > int'(PU_WRITE_CNT) + 1 |-> read_ready && write_ready) else $error("ready too late");
  busy_len_a: assert property (@(posedge clk) disable iff (!nrst) s_busy_end |->
    int'(busy_r) + 3 >= int'(WRITE_CNT) && int'(busy_r) <= int'(WRITE_CNT) + 3) else $error("write cycle length off");
  latch_clear_a: assert property (@(posedge clk) disable iff (!nrst) s_busy_end |-> ##[0:2] !status_o[1])
    else $error("latch kept after write cycle");
  busy_start_a: assert property (@(posedge clk) disable iff (!nrst) s_busy_start |->
    cs_n && desel_r >= 8'h01 && desel_r <= 8'h08) else $error("write began away from cs_n rise");
  oe_start_a: assert property (@(posedge sck) disable iff (!nrst) $rose(so_oe) |->
    rise_r == 6'h09 || rise_r == 6'h11) else $error("so drive began at wrong clock");
endmodule

bind esq_top esq_props #(.PU_READ_CNT(PU_READ_CNT), .PU_WRITE_CNT(PU_WRITE_CNT), .WRITE_CNT(WRITE_CNT)) u_props (
  .clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe),
  .wp_n(wp_n), .status_o(status_o), .read_ready(read_ready), .write_ready(write_ready));

//--- esq_host.sv
// host serial master model: 64 ns sck that stands low between frames
// assumes the caller leaves time between frames; so is resolved here
`timescale 1ns/1ps
module esq_host (
  // link toward the device
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  // device answer
  input wire logic so,
  input wire logic so_oe
);
  logic last_r;
  logic so_w;

  // a released line shows the inverse of its last driven level
  assign so_w = so_oe ? so : ~last_r;
  always @(so or so_oe) if (so_oe) last_r = so;

  // idle levels from time zero, deselected
  initial begin
    last_r = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // pause with sck high, garbage clocks meanwhile, resume with sck high
  task automatic pause();
    logic keep;
    keep = si;
    #10 hold_n = 1'b0;
    repeat (3) begin
      si = ~si;
      #32 sck = 1'b0;
      #32 sck = 1'b1;
    end
    si = keep;
    #10 hold_n = 1'b1;
  endtask

  // n bits msb first from tx; so captured on each falling edge
  task automatic frame(input int n, input logic [63:0] tx, input int hold_at, output logic [63:0] rx,
                       output logic oe_seen);
    rx = 64'h0;
    oe_seen = 1'b0;
    #13 cs_n = 1'b0;
    #500;
    for (int i = n - 1; i >= 0; i--) begin
      #32 sck = 1'b1;
      #8 si = tx[i]; // si moves well away from the sampling fall
      if (i == hold_at) pause();
      #24 sck = 1'b0;
      rx = {rx[62:0], so_w};
      oe_seen = oe_seen | so_oe;
    end
    #500 cs_n = 1'b1;
    si = ~si;
    #900;
  endtask
endmodule

//--- spi_eeprom_command_sequencer_test.sv
// self-checking bench: host model drives the link, a byte array predicts results
// assumes esq_host and the bound checker compile alongside
`timescale 1ns/1ps
module spi_eeprom_command_sequencer_test;
  import esq_pkg::*;
  localparam int unsigned WCNT = 100;
  logic clk, nrst, wp_n, sck, cs_n, si, hold_n, so, so_oe, read_ready, write_ready, oe, latch_m;
  logic [7:0] status_o;
  logic [7:0] mem [256];
  logic [7:0] pg [3] = '{8'hfc, 8'h00, 8'h10};
  logic [7:0] pb [3] = '{8'h7f, 8'h80, 8'hc0};
  logic [63:0] rx;
  logic [4:0][7:0] db;
  logic [1:0] prot;
  int error_cnt, comparisons;

  esq_top #(.PU_READ_CNT(10), .PU_WRITE_CNT(20), .WRITE_CNT(WCNT)) u_dut (.clk(clk), .nrst(nrst),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .status_o(status_o), .read_ready(read_ready), .write_ready(write_ready));
  esq_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

  // 10 MHz system clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [7:0] exp_st();
    exp_st = {4'h0, prot, latch_m, 1'b0};
  endfunction

  function automatic logic prot_hit(input logic [7:0] a);
    prot_hit = prot == 2'h3 || (prot == 2'h2 && a >= 8'h80) || (prot == 2'h1 && a >= 8'hc0);
  endfunction

  // one frame, then settle to a falling clk edge before looking at status_o
  task automatic fr(input int n, input logic [63:0] tx, input int h);
    u_host.frame(n, tx, h, rx, oe);
    @(negedge clk);
  endtask

  task automatic latch_set();
    fr(8, {56'h0, OP_WRITE_LATCH_SET}, -1);
    latch_m = 1'b1;
    check(status_o, exp_st());
  endtask

  // during the write cycle: status reads answer, other commands are ignored
  task automatic busy_phase();
    int n;
    n = 0;
    check(status_o, 8'hff);
    fr(16, {48'h0, OP_STATUS_READ, 8'h00}, -1);
    check(rx[7:0], 8'hff);
    fr(24, {40'h0, OP_ARRAY_READ, 16'h0}, -1);
    check({7'h0, oe}, 8'h00);
    while (status_o[0] !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      error_cnt++;
      conclude();
    end
    latch_m = 1'b0;
    repeat (2) @(negedge clk);
    check(status_o, exp_st());
  endtask

  // array write of nb random bytes, extra stray bits before cs_n rises
  task automatic wr(input logic [7:0] a, input int nb, input int extra);
    logic [63:0] tx;
    logic go;
    tx = {48'h0, OP_ARRAY_WRITE, a};
    for (int k = 0; k < nb; k++) begin
      db[k] = 8'($urandom);
      tx = {tx[55:0], db[k]};
    end
    tx = tx << extra;
    go = latch_m && wp_n && extra == 0;
    fr(16 + 8 * nb + extra, tx, -1);
    if (go) begin
      for (int k = 0; k < nb; k++) if (!prot_hit(a)) mem[{a[7:2], a[1:0] + 2'(k)}] = db[k];
      busy_phase();
    end else begin
      check(status_o, exp_st());
    end
  endtask

  task automatic rd(input logic [7:0] a, input int nb, input int h);
    fr(16 + 8 * nb, {48'h0, OP_ARRAY_READ, a} << (8 * nb), h);
    for (int k = 0; k < nb; k++) check(rx[8 * (nb - 1 - k) +: 8], mem[8'(a + k)]);
  endtask

  task automatic sw(input logic [1:0] p);
    latch_set();
    fr(16, {48'h0, OP_STATUS_WRITE, 4'h0, p, 2'h0}, -1);
    prot = p;
    busy_phase();
    fr(16, {48'h0, OP_STATUS_READ, 8'h00}, -1);
    check(rx[7:0], exp_st());
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    latch_m = 1'b0;
    prot = 2'h0;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(77704));
    repeat (8) @(posedge clk);
    check(status_o, 8'h00);
    check({7'h0, so_oe}, 8'h00);
    nrst <= 1'b1;
    repeat (5) @(negedge clk);
    check({6'h0, read_ready, write_ready}, 8'h00);
    repeat (10) @(negedge clk);
    check({6'h0, read_ready, write_ready}, 8'h02);
    repeat (10) @(negedge clk);
    check({6'h0, read_ready, write_ready}, 8'h03);
    $display("test power_up done");
    wr(8'h10, 1, 0);
    for (int i = 0; i < 3; i++) begin
      latch_set();
      wr(pg[i], 4, 0);
    end
    rd(8'hfe, 4, -1);
    rd(8'h10, 4, 12);
    latch_set();
    wr(8'h12, 5, 0);
    rd(8'h10, 4, -1);
    $display("test write_read done");
    fr(9, {55'h0, OP_WRITE_LATCH_SET, 1'b0}, -1);
    check(status_o, exp_st());
    latch_set();
    wr(8'h10, 2, 3);
    @(posedge clk) wp_n <= 1'b0;
    @(negedge clk);
    wr(8'h10, 1, 0);
    @(posedge clk) wp_n <= 1'b1;
    fr(8, {56'h0, OP_WRITE_LATCH_CLEAR}, -1);
    latch_m = 1'b0;
    check(status_o, exp_st());
    rd(8'h10, 4, -1);
    $display("test refusals done");
    for (int p = 0; p < 4; p++) begin
      sw(2'(p));
      for (int i = 0; i < 3; i++) begin
        latch_set();
        wr(pb[i], 1, 0);
        rd(pb[i], 1, -1);
      end
    end
    $display("test protect done");
    conclude();
  end
endmodule
